// ---- rtl/vsdd_controller.sv ----
// Memory side of the combined video and memory controller.
// Assumes processor address and direction arrive from pins; the oscillator is a pin level.
`default_nettype none
`include "vsdd_defines.svh"
module vsdd_controller import vsdd_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic osc_in,
	input wire logic cpu_strobe,
	input wire logic cpu_write,
	input wire logic [17:0] cpu_addr,
	input wire logic frame_start,
	output logic cpu_done,
	output logic master_clock,
	output logic row_strobe_n,
	output logic bank0_column_strobe_n,
	output logic bank1_column_strobe_n,
	output logic ram_write_strobe_n,
	output logic row_column_select,
	output logic video_address_select,
	output logic transceiver_output_enable_n,
	output logic [7:0] video_ram_address,
	output logic rom_output_enable,
	output logic cartridge_select,
	output logic peripheral_select_n
);
	vsdd_cpu_type cpu_meta;
	vsdd_cpu_type cpu_sync;
	logic osc_meta;
	logic osc_sync;
	logic osc_last;
	vsdd_state_type state;
	vsdd_state_type next_state;
	logic [2:0] phase;
	logic [2:0] next_phase;
	logic owner_video;
	logic next_owner_video;
	vsdd_dram_type dram;
	vsdd_dram_type next_dram;
	logic [7:0] next_video_ram_address;
	logic next_cpu_done;
	logic next_master_clock;
	logic next_rom_output_enable;
	logic next_cartridge_select;
	logic next_peripheral_select_n;
	logic fetch_req;
	logic fetch_done;
	logic [15:0] fetch_addr;
	logic cpu_in_ram;
	logic cpu_in_rom;
	logic cpu_in_cart;

	vsdd_video_addr_gen #(
		.ADDR_WIDTH(16)
	) u_video (
		.clk(clk),
		.rst(rst),
		.frame_start(frame_start),
		.fetch_done(fetch_done),
		.fetch_req(fetch_req),
		.fetch_addr(fetch_addr)
	);

	// ====================================================================
	// Pin synchronisers
	always_ff @(posedge clk) begin
		if (rst) begin
			cpu_meta <= '0;
			cpu_sync <= '0;
			osc_meta <= 1'b0;
			osc_sync <= 1'b0;
			osc_last <= 1'b0;
		end else begin
			cpu_meta <= '{req: cpu_strobe, write: cpu_write, addr: cpu_addr};
			cpu_sync <= cpu_meta;
			osc_meta <= osc_in;
			osc_sync <= osc_meta;
			osc_last <= osc_sync;
		end
	end

	// ====================================================================
	// Address decode
	always_comb begin
		cpu_in_rom = cpu_sync.addr <= `VSDD_ROM_LAST;
		cpu_in_cart = (cpu_sync.addr >= `VSDD_CART_FIRST)
			&& (cpu_sync.addr <= `VSDD_CART_LAST);
		cpu_in_ram = cpu_sync.addr >= `VSDD_RAM_FIRST;
		next_rom_output_enable = cpu_sync.req && !cpu_sync.write && cpu_in_rom;
		next_cartridge_select = cpu_sync.req && cpu_in_cart;
		next_peripheral_select_n = !(cpu_sync.req
			&& cpu_sync.addr[17] == `VSDD_PERIPH_A17
			&& cpu_sync.addr[16] == `VSDD_PERIPH_A16
			&& cpu_sync.addr[6] == `VSDD_PERIPH_A6);
		next_master_clock = master_clock;
		if (osc_sync && !osc_last) begin
			next_master_clock = !master_clock;
		end
	end

	// ====================================================================
	// DRAM sequencer
	always_comb begin
		next_state = state;
		next_phase = phase;
		next_owner_video = owner_video;
		next_dram = dram;
		next_video_ram_address = video_ram_address;
		next_cpu_done = 1'b0;
		fetch_done = 1'b0;
		case (state)
			VSDD_IDLE: begin
				next_dram = '{row_strobe_n: 1'b1, bank0_column_strobe_n: 1'b1,
					bank1_column_strobe_n: 1'b1, ram_write_strobe_n: 1'b1,
					row_column_select: 1'b1, video_address_select: 1'b0,
					transceiver_output_enable_n: 1'b1};
				if (fetch_req) begin
					next_owner_video = 1'b1;
					next_dram.video_address_select = 1'b1;
					next_video_ram_address = fetch_addr[7:0];
					next_state = VSDD_ROW;
				end else if (cpu_sync.req && cpu_in_ram && !cpu_done) begin
					next_owner_video = 1'b0;
					next_dram.transceiver_output_enable_n = 1'b0;
					next_state = VSDD_ROW;
				end
			end
			VSDD_ROW: begin
				next_dram.row_strobe_n = 1'b0;
				next_dram.ram_write_strobe_n = owner_video || !cpu_sync.write;
				next_state = VSDD_COL;
			end
			VSDD_COL: begin
				next_dram.row_column_select = 1'b0;
				if (owner_video) begin
					next_video_ram_address = fetch_addr[15:8];
					next_dram.bank0_column_strobe_n = 1'b0;
				end else begin
					next_dram.bank0_column_strobe_n = cpu_sync.addr[`VSDD_BANK_BIT];
					next_dram.bank1_column_strobe_n = !cpu_sync.addr[`VSDD_BANK_BIT];
				end
				next_phase = `VSDD_PHASE_COUNT;
				next_state = VSDD_HOLD;
			end
			VSDD_HOLD: begin
				next_phase = phase - 3'h1;
				if (phase == 3'h1) begin
					next_state = VSDD_DONE;
				end
			end
			VSDD_DONE: begin
				next_dram.row_strobe_n = 1'b1;
				next_dram.bank0_column_strobe_n = 1'b1;
				next_dram.bank1_column_strobe_n = 1'b1;
				next_dram.ram_write_strobe_n = 1'b1;
				next_dram.row_column_select = 1'b1;
				next_dram.video_address_select = 1'b0;
				next_dram.transceiver_output_enable_n = 1'b1;
				if (owner_video) begin
					fetch_done = 1'b1;
				end else begin
					next_cpu_done = 1'b1;
				end
				next_state = VSDD_IDLE;
			end
			default: begin
				next_state = VSDD_IDLE;
			end
		endcase
		if (cpu_sync.req && cpu_done) begin
			next_cpu_done = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state <= VSDD_IDLE;
			phase <= 3'h0;
			owner_video <= 1'b0;
			dram <= '{row_strobe_n: 1'b1, bank0_column_strobe_n: 1'b1,
				bank1_column_strobe_n: 1'b1, ram_write_strobe_n: 1'b1,
				row_column_select: 1'b1, video_address_select: 1'b0,
				transceiver_output_enable_n: 1'b1};
			video_ram_address <= 8'h00;
			cpu_done <= 1'b0;
			master_clock <= 1'b0;
			rom_output_enable <= 1'b0;
			cartridge_select <= 1'b0;
			peripheral_select_n <= 1'b1;
		end else begin
			state <= next_state;
			phase <= next_phase;
			owner_video <= next_owner_video;
			dram <= next_dram;
			video_ram_address <= next_video_ram_address;
			cpu_done <= next_cpu_done;
			master_clock <= next_master_clock;
			rom_output_enable <= next_rom_output_enable;
			cartridge_select <= next_cartridge_select;
			peripheral_select_n <= next_peripheral_select_n;
		end
	end

	// ====================================================================
	// Strobe outputs
	always_comb begin
		row_strobe_n = dram.row_strobe_n;
		bank0_column_strobe_n = dram.bank0_column_strobe_n;
		bank1_column_strobe_n = dram.bank1_column_strobe_n;
		ram_write_strobe_n = dram.ram_write_strobe_n;
		row_column_select = dram.row_column_select;
		video_address_select = dram.video_address_select;
		transceiver_output_enable_n = dram.transceiver_output_enable_n;
	end
endmodule : vsdd_controller
`default_nettype wire

// ---- rtl/vsdd_defines.svh ----
// Constants for the shared video/processor DRAM controller and address decode.
// Assumes a 40 MHz system clock and an 8-bit processor with an 18-bit address bus.
// ====================================================================
`ifndef VSDD_DEFINES_SVH
`define VSDD_DEFINES_SVH
`define VSDD_ROM_LAST 18'h0BFFF
`define VSDD_CART_FIRST 18'h0C000
`define VSDD_CART_LAST 18'h0FFFF
`define VSDD_RAM_FIRST 18'h20000
`define VSDD_RAM_LAST 18'h3FFFF
`define VSDD_BANK_BIT 16
`define VSDD_PERIPH_A17 1'h0
`define VSDD_PERIPH_A16 1'h1
`define VSDD_PERIPH_A6 1'h0
`define VSDD_FETCH_GAP 8'h1F
`define VSDD_PHASE_COUNT 3'h4
`endif

// ---- rtl/vsdd_pkg.sv ----
// Types shared by the DRAM controller files.
// Assumes the defines header is compiled alongside.
`default_nettype none
package vsdd_pkg;
	typedef enum logic [2:0] {
		VSDD_IDLE, VSDD_ROW, VSDD_COL, VSDD_HOLD, VSDD_DONE
	} vsdd_state_type;
	typedef struct packed {
		logic req;
		logic write;
		logic [17:0] addr;
	} vsdd_cpu_type;
	typedef struct packed {
		logic row_strobe_n;
		logic bank0_column_strobe_n;
		logic bank1_column_strobe_n;
		logic ram_write_strobe_n;
		logic row_column_select;
		logic video_address_select;
		logic transceiver_output_enable_n;
	} vsdd_dram_type;
endpackage : vsdd_pkg
`default_nettype wire

// ---- rtl/vsdd_video_addr_gen.sv ----
// Display fetch address sequencer.
// Assumes a one-cycle frame start pulse from the picture timing logic.
`default_nettype none
`include "vsdd_defines.svh"
module vsdd_video_addr_gen import vsdd_pkg::*; #(
	parameter int ADDR_WIDTH = 16
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic frame_start,
	input wire logic fetch_done,
	output logic fetch_req,
	output logic [ADDR_WIDTH-1:0] fetch_addr
);
	logic [7:0] gap;
	logic [7:0] next_gap;
	logic [ADDR_WIDTH-1:0] next_fetch_addr;
	logic next_fetch_req;

	if (ADDR_WIDTH != 16) begin : g_width_check
		$error("vsdd_video_addr_gen: ADDR_WIDTH must be 16");
	end

	// ====================================================================
	// Fixed fetch sequence
	always_comb begin
		next_gap = gap;
		next_fetch_addr = fetch_addr;
		next_fetch_req = fetch_req;
		if (frame_start) begin
			next_fetch_addr = '0;
			next_gap = `VSDD_FETCH_GAP;
			next_fetch_req = 1'b0;
		end else if (fetch_req) begin
			if (fetch_done) begin
				next_fetch_req = 1'b0;
				next_fetch_addr = fetch_addr + 1'b1;
				next_gap = `VSDD_FETCH_GAP;
			end
		end else if (gap == 8'h00) begin
			next_fetch_req = 1'b1;
		end else begin
			next_gap = gap - 8'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			gap <= `VSDD_FETCH_GAP;
			fetch_addr <= '0;
			fetch_req <= 1'b0;
		end else begin
			gap <= next_gap;
			fetch_addr <= next_fetch_addr;
			fetch_req <= next_fetch_req;
		end
	end
endmodule : vsdd_video_addr_gen
`default_nettype wire

// ---- verification/tb_vsdd_controller.sv ----
// Self-checking bench for the shared DRAM controller.
// Assumes a 40 MHz clock and a free running 15 MHz oscillator pin.
`default_nettype none
module tb_vsdd_controller;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'h0, rst = 1'h1, osc_in = 1'h0, req = 1'h0, wr = 1'h0, frame_start = 1'h0;
	logic clr = 1'h0, vid_seen = 1'h0, mc_prev;
	logic [17:0] ad = 18'h00000, cpu_addr;
	logic cpu_strobe, cpu_write, cpu_done, master_clock, row_n, cas0_n, cas1_n, we_n, col_sel;
	logic vid_sel, xcvr_n, rom_oe, cart_sel, periph_n;
	logic [7:0] vaddr;
	logic [8:0] saw = 9'h000;
	logic vid_prev = 1'h0, cas0_prev = 1'h1;
	logic [15:0] fetch_exp = 16'h0000;
	int num_errors = 0, check_count = 0, toggles;
	logic [17:0] corner [8] = '{18'h0BFFF, 18'h0C000, 18'h0FFFF, 18'h20000, 18'h2FFFF,
		18'h30000, 18'h3FFFF, 18'h10000};
	always #12.5 clk = !clk;
	always #33.333 osc_in = !osc_in;
	vsdd_cpu_model u_cpu (.clk(clk), .req(req), .wr(wr), .ad(ad), .cpu_done(cpu_done),
		.cpu_strobe(cpu_strobe), .cpu_write(cpu_write), .cpu_addr(cpu_addr));
	vsdd_controller u_dut (.clk(clk), .rst(rst), .osc_in(osc_in), .cpu_strobe(cpu_strobe),
		.cpu_write(cpu_write), .cpu_addr(cpu_addr), .frame_start(frame_start),
		.cpu_done(cpu_done), .master_clock(master_clock), .row_strobe_n(row_n),
		.bank0_column_strobe_n(cas0_n), .bank1_column_strobe_n(cas1_n),
		.ram_write_strobe_n(we_n), .row_column_select(col_sel),
		.video_address_select(vid_sel), .transceiver_output_enable_n(xcvr_n),
		.video_ram_address(vaddr), .rom_output_enable(rom_oe), .cartridge_select(cart_sel),
		.peripheral_select_n(periph_n));
	// ====
	// Pin activity seen during one access
	always @(posedge clk) begin
		if (vid_sel === 1'h1) vid_seen <= 1'h1;
		if (clr) saw <= 9'h000;
		else saw <= saw | {!xcvr_n, !periph_n, cart_sel, rom_oe, !we_n, !xcvr_n && !cas1_n,
			!xcvr_n && !cas0_n, !xcvr_n && !col_sel, !xcvr_n && !row_n};
	end
	function automatic logic [8:0] expect_seen(input logic w, input logic [17:0] a);
		return {a[17], a[17:16] == 2'h1 && !a[6], a >= 18'h0C000 && a <= 18'h0FFFF,
			!w && a <= 18'h0BFFF, a[17] && w, a[17] && a[16], a[17] && !a[16], a[17], a[17]};
	endfunction : expect_seen
	task automatic check_bits(input logic [8:0] got, input logic [8:0] exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check_bits
	task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t fetch address got=%h exp=%h", $time, got, exp);
		end
	endtask : check_byte
	// ====
	// Display fetch address: row byte with video select, column byte with bank strobe
	always @(negedge clk) begin
		if (frame_start === 1'h1) begin
			fetch_exp = 16'h0000;
		end else if (vid_sel === 1'h1 && vid_prev !== 1'h1) begin
			check_byte(vaddr, fetch_exp[7:0]);
		end else if (vid_sel === 1'h1 && cas0_n === 1'h0 && cas0_prev === 1'h1) begin
			check_byte(vaddr, fetch_exp[15:8]);
			fetch_exp = fetch_exp + 16'h0001;
		end
		vid_prev = vid_sel;
		cas0_prev = cas0_n;
	end
	task automatic access(input logic w, input logic [17:0] a);
		int n;
		clr <= 1'h1;
		wr <= w;
		ad <= a;
		@(negedge clk);
		clr <= 1'h0;
		req <= 1'h1;
		n = 0;
		while (cpu_done !== 1'h1 && n < (a[17] ? 200 : 10)) begin
			@(negedge clk);
			n++;
		end
		req <= 1'h0;
		if (a[17]) check_bits({8'h00, cpu_done}, 9'h001);
		check_bits(saw, expect_seen(w, a));
		n = 0;
		while (cpu_done !== 1'h0 && n < 50) begin
			@(negedge clk);
			n++;
		end
		repeat (4) @(negedge clk);
	endtask : access
	task automatic results();
		$display("errors=%0d checks=%0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : results
	// ====
	// Main sequence
	initial begin
		void'($urandom(18));
		repeat (10) @(negedge clk);
		rst <= 1'h0;
		repeat (4) @(negedge clk);
		frame_start <= 1'h1;
		@(negedge clk);
		frame_start <= 1'h0;
		for (int i = 0; i < 8; i++) access(i[0], corner[i]);
		for (int i = 0; i < 24; i++) access(1'($urandom), 18'($urandom));
		check_bits({8'h00, vid_seen}, 9'h001);
		toggles = 0;
		mc_prev = master_clock;
		repeat (300) begin
			@(negedge clk);
			if (master_clock !== mc_prev) toggles++;
			mc_prev = master_clock;
		end
		check_bits({8'h00, toggles >= 110 && toggles <= 115}, 9'h001);
		results();
	end
	initial begin
		#1000000;
		num_errors++;
		results();
	end
endmodule : tb_vsdd_controller
`default_nettype wire

// ---- verification/vsdd_checker.sv ----
// Pin assertions for the shared DRAM controller.
// Bound to every vsdd_controller instance; one clock domain.
`default_nettype none
module vsdd_checker (
	input wire logic clk,
	input wire logic rst,
	input wire logic cpu_strobe,
	input wire logic cpu_write,
	input wire logic [17:0] cpu_addr,
	input wire logic cpu_done,
	input wire logic master_clock,
	input wire logic row_strobe_n,
	input wire logic bank0_column_strobe_n,
	input wire logic bank1_column_strobe_n,
	input wire logic ram_write_strobe_n,
	input wire logic row_column_select,
	input wire logic video_address_select,
	input wire logic transceiver_output_enable_n,
	input wire logic rom_output_enable,
	input wire logic cartridge_select,
	input wire logic peripheral_select_n
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// ====
	// Assertions
	a_one_bank: assert property (bank0_column_strobe_n || bank1_column_strobe_n)
		else $error("both bank strobes low");
	a_cas_in_ras: assert property (!(bank0_column_strobe_n && bank1_column_strobe_n)
		|-> !row_strobe_n)
		else $error("bank strobe without row strobe");
	a_col_in_row: assert property ($fell(row_column_select) |-> !row_strobe_n)
		else $error("column half without row strobe");
	a_write_cpu: assert property (!ram_write_strobe_n |-> !transceiver_output_enable_n)
		else $error("write strobe outside processor cycle");
	a_video_iso: assert property (video_address_select |-> transceiver_output_enable_n)
		else $error("transceiver on during display fetch");
	a_rom_read: assert property (rom_output_enable |-> !$past(cpu_write)
		&& $past(cpu_addr) <= 18'h0BFFF)
		else $error("rom enable outside rom read");
	a_cart_only: assert property (cartridge_select |-> $past(cpu_addr[17:14]) == 4'h3)
		else $error("cartridge select outside its region");
	a_periph_dec: assert property (!peripheral_select_n |->
		$past(cpu_addr[17:16]) == 2'h1 && !$past(cpu_addr[6]))
		else $error("peripheral select wrong decode");
	a_cpu_wait: assert property ($rose(cpu_strobe) && cpu_addr[17] |-> ##[9:120] cpu_done)
		else $error("processor ram cycle not answered");
	a_master_half: assert property ($changed(master_clock) |=> $stable(master_clock))
		else $error("master clock too fast");
	c_cpu_done: cover property ($rose(cpu_done));
	c_video: cover property ($rose(video_address_select));
	c_periph: cover property ($fell(peripheral_select_n));
endmodule : vsdd_checker
bind vsdd_controller vsdd_checker u_checker (.clk, .rst, .cpu_strobe, .cpu_write, .cpu_addr,
	.cpu_done, .master_clock, .row_strobe_n, .bank0_column_strobe_n, .bank1_column_strobe_n,
	.ram_write_strobe_n, .row_column_select, .video_address_select,
	.transceiver_output_enable_n, .rom_output_enable, .cartridge_select, .peripheral_select_n);
`default_nettype wire

// ---- verification/vsdd_cpu_model.sv ----
// Processor bus model: holds each access until the controller answers or the request is withdrawn.
// Assumes req, wr and ad change at the falling clock edge.
`default_nettype none
module vsdd_cpu_model (
	input wire logic clk,
	input wire logic req,
	input wire logic wr,
	input wire logic [17:0] ad,
	input wire logic cpu_done,
	output logic cpu_strobe = 1'h0,
	output logic cpu_write = 1'h0,
	output logic [17:0] cpu_addr = 18'h00000
);
	timeunit 1ns;
	timeprecision 1ps;
	// ====
	// Start on request, end on answer or withdrawal
	always @(negedge clk) begin
		if (!cpu_strobe && req && !cpu_done) begin
			cpu_write <= wr;
			cpu_addr <= ad;
			cpu_strobe <= 1'h1;
		end else if (cpu_strobe && (cpu_done || !req)) begin
			cpu_strobe <= 1'h0;
		end
	end
endmodule : vsdd_cpu_model
`default_nettype wire
